// ==== design/fmq_event_logic.sv ====
/*
 * receive timing, queues and event/interrupt logic of an fsk loop modem.
 * assumes the analog demodulator supplies tone and byte strobes, the modulator
 * asks for bytes, and the controller side supplies config bits as levels.
 */
`include "fmq_map.svh"
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - demodulator listens whenever not transmitting
// - carrier detect after three mark periods
// - uart mode auto-drains receive queue out
// - byte enqueued 1.5 bit periods after end
// - one character may trail carrier loss
// - spi reads dequeue within a cycle
// - interrupt edge/level and polarity selectable
// - spi-only: irq on uart pin, uart off
// - break mode: irq on sdo or messages
// - mask bit one blocks a flag
// - rts withdrawn sets flag, re-enables demodulator
// - carrier found sets carrier-on flag
// - carrier lost sets carrier-off flag
// - auto enqueue above threshold sets level flag
// - receive full flag, later bytes lost
// - controller dequeue to empty sets flag
// - rts without carrier gives cts, modulates
// - auto dequeue below threshold sets level flag
// - drained transmit queue sets empty flag
module fmq_event_logic #(
    parameter int DEPTH = `FMQ_QUEUE_DEPTH,
    parameter int BIT_CYC = `FMQ_BIT_CYC,
    parameter int FAST_BIT_CYC = `FMQ_FAST_BIT_CYC,
    parameter int CD_CYC = `FMQ_CD_CYC,
    parameter int ENQ_CYC = `FMQ_ENQ_CYC,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // demodulator side
    input wire logic rxFilteredInput,
    input wire logic rxMarkTone,
    input wire logic rxCarrierValid,
    input wire logic rxByteDone,
    input wire logic [7:0] rxByteData,
    output logic demodEnable,
    output logic carrierDetect,
    // modulator side
    output logic modEnable,
    output logic modByteValid,
    input wire logic modByteReady,
    output logic [7:0] modByteData,
    // controller data ports
    input wire logic txWrValid,
    output logic txWrReady,
    input wire logic [7:0] txWrData,
    input wire logic rxRdReq,
    output logic rxRdValid,
    output logic [7:0] rxRdData,
    // configuration levels
    input wire logic rtsPin_b,
    input wire logic rtsCfg,
    input wire logic serialPortDisable,
    input wire logic uartBreakMode,
    input wire logic irqPinEnable,
    input wire logic breakMessageIrqEnable,
    input wire logic irqSensitivitySelect,
    input wire logic irqPolaritySelect,
    input wire logic [CW-1:0] rxThreshold,
    input wire logic [CW-1:0] txThresholdField,
    // status
    input wire logic [`FMQ_ST_WIDTH-1:0] statusMask,
    input wire logic [`FMQ_ST_WIDTH-1:0] statusClear,
    output logic [`FMQ_ST_WIDTH-1:0] status,
    output logic [CW-1:0] rxFill,
    output logic [CW-1:0] txFill,
    // pins and interrupt routes
    output logic serialTxOut,
    output logic irqSdoOut,
    output logic irqSdoOe,
    output logic breakIrqMsg
);
    fmq_pkg::fmq_link_type link_r;
    logic [17:0] cdTimer_r;
    logic [17:0] enqTimer_r;
    logic [17:0] baudTimer_r;
    logic [7:0] pendByte_r;
    logic pending_r;
    logic rtsActive;
    logic rtsPrev_r;
    logic uartOn;
    logic rxPushValid;
    logic rxPushReady;
    logic rxPopValid;
    logic rxPopReady;
    logic [7:0] rxPopData;
    logic [CW-1:0] rxFillNow;
    logic [CW-1:0] txFillNow;
    logic txPush;
    logic txPop;
    logic [9:0] shift_r;
    logic [3:0] bitsLeft_r;
    logic uartLoad;
    logic [`FMQ_ST_WIDTH-1:0] status_r;
    logic [`FMQ_ST_WIDTH-1:0] setEv;
    logic irqAny;
    logic irqAnyPrev_r;
    logic irqAssert;
    logic irqPinLevel;
    logic serialTxOut_r;
    logic rxRdValid_r;
    logic [7:0] rxRdData_r;
    logic breakIrqMsg_r;

    // a request to send comes from the pin (low) or the config bit
    assign rtsActive = !rtsPin_b | rtsCfg;
    assign uartOn = !serialPortDisable;
    assign modEnable = (link_r == fmq_pkg::LINK_SEND);
    assign demodEnable = !modEnable;
    assign carrierDetect = (link_r == fmq_pkg::LINK_CARRIER);

    // link arbitration; receive has priority while carrier stays
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_r <= fmq_pkg::LINK_LISTEN;
        end else begin
            case (link_r)
                fmq_pkg::LINK_LISTEN: begin
                    if (cdTimer_r == 18'(CD_CYC)) begin
                        link_r <= fmq_pkg::LINK_CARRIER;
                    end else if (rtsActive) begin
                        link_r <= fmq_pkg::LINK_SEND;
                    end
                end
                fmq_pkg::LINK_CARRIER: begin
                    if (!rxCarrierValid) begin
                        link_r <= fmq_pkg::LINK_LISTEN;
                    end
                end
                fmq_pkg::LINK_SEND: begin
                    if (!rtsActive) begin
                        link_r <= fmq_pkg::LINK_LISTEN;
                    end
                end
                default: link_r <= fmq_pkg::LINK_LISTEN;
            endcase
        end
    end

    // count continuous mark tone while listening
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cdTimer_r <= `FMQ_TIMER_RESET;
        end else if (link_r != fmq_pkg::LINK_LISTEN || !rxCarrierValid || !rxMarkTone) begin
            cdTimer_r <= `FMQ_TIMER_RESET;
        end else if (cdTimer_r != 18'(CD_CYC)) begin
            cdTimer_r <= cdTimer_r + 18'h00001;
        end
    end

    // hold each decoded byte for 1.5 bit periods before queueing
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_r <= 1'b0;
            pendByte_r <= 8'h00;
            enqTimer_r <= `FMQ_TIMER_RESET;
        end else if (rxByteDone && demodEnable) begin
            pending_r <= 1'b1;
            pendByte_r <= rxByteData;
            enqTimer_r <= 18'(ENQ_CYC);
        end else if (pending_r && enqTimer_r != `FMQ_TIMER_RESET) begin
            enqTimer_r <= enqTimer_r - 18'h00001;
        end else if (pending_r) begin
            pending_r <= 1'b0;
        end
    end
    // a full queue refuses the push and the byte is dropped
    assign rxPushValid = pending_r && (enqTimer_r == `FMQ_TIMER_RESET);

    fmq_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) rxQueue (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .inValid(rxPushValid),
        .inReady(rxPushReady),
        .inData(pendByte_r),
        .outValid(rxPopValid),
        .outReady(rxPopReady),
        .outData(rxPopData),
        .fill(rxFillNow)
    );

    // uart mode drains automatically, otherwise controller reads
    assign uartLoad = uartOn && rxPopValid && (bitsLeft_r == 4'h0);
    assign rxPopReady = uartOn ? uartLoad : rxRdReq;

    // controller read answer, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxRdValid_r <= 1'b0;
            rxRdData_r <= 8'h00;
        end else begin
            rxRdValid_r <= !uartOn && rxRdReq && rxPopValid;
            if (!uartOn && rxRdReq && rxPopValid) begin
                rxRdData_r <= rxPopData;
            end
        end
    end
    assign rxRdValid = rxRdValid_r;
    assign rxRdData = rxRdData_r;

    // serial framer: start, eight data lsb first, stop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= 10'h3ff;
            bitsLeft_r <= 4'h0;
            baudTimer_r <= `FMQ_TIMER_RESET;
        end else if (uartLoad) begin
            shift_r <= {1'b1, rxPopData, 1'b0};
            bitsLeft_r <= `FMQ_FRAME_BITS;
            baudTimer_r <= uartBreakMode ? 18'(FAST_BIT_CYC - 1) : 18'(BIT_CYC - 1);
        end else if (bitsLeft_r != 4'h0) begin
            if (baudTimer_r == `FMQ_TIMER_RESET) begin
                shift_r <= {1'b1, shift_r[9:1]};
                bitsLeft_r <= bitsLeft_r - 4'h1;
                baudTimer_r <= uartBreakMode ? 18'(FAST_BIT_CYC - 1) : 18'(BIT_CYC - 1);
            end else begin
                baudTimer_r <= baudTimer_r - 18'h00001;
            end
        end
    end

    // transmit queue, filled by controller, drained by modulator
    assign txPush = txWrValid && txWrReady;
    assign txPop = modByteValid && modByteReady && modEnable;

    fmq_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) txQueue (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .inValid(txWrValid),
        .inReady(txWrReady),
        .inData(txWrData),
        .outValid(modByteValid),
        .outReady(modByteReady && modEnable),
        .outData(modByteData),
        .fill(txFillNow)
    );
    assign rxFill = rxFillNow;
    assign txFill = txFillNow;

    // previous request level for withdrawal detection
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rtsPrev_r <= 1'b0;
        end else begin
            rtsPrev_r <= rtsActive;
        end
    end

    // events that set status flags
    always_comb begin
        setEv = `FMQ_ST_RESET;
        setEv[`FMQ_ST_CTS_OFF] = rtsPrev_r && !rtsActive;
        setEv[`FMQ_ST_CD_ON] = (link_r == fmq_pkg::LINK_LISTEN) && (cdTimer_r == 18'(CD_CYC));
        setEv[`FMQ_ST_CD_OFF] = carrierDetect && !rxCarrierValid;
        setEv[`FMQ_ST_RX_LEVEL] = rxPushValid && rxPushReady && !(rxPopValid && rxPopReady)
            && (rxFillNow == rxThreshold);
        setEv[`FMQ_ST_RX_FULL] = rxPushValid && rxPushReady && !(rxPopValid && rxPopReady)
            && (rxFillNow == CW'(DEPTH - 1));
        setEv[`FMQ_ST_RX_EMPTY] = rxPopValid && rxPopReady && !(rxPushValid && rxPushReady)
            && (rxFillNow == CW'(1));
        setEv[`FMQ_ST_CTS_ON] = (link_r == fmq_pkg::LINK_LISTEN) && rtsActive
            && (cdTimer_r != 18'(CD_CYC));
        setEv[`FMQ_ST_TX_LEVEL] = txPop && !txPush && (txFillNow == txThresholdField);
        setEv[`FMQ_ST_TX_FULL] = txPush && !txPop && (txFillNow == CW'(DEPTH - 1));
        setEv[`FMQ_ST_TX_EMPTY] = txPop && !txPush && (txFillNow == CW'(1));
    end

    // sticky flags, a set beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= `FMQ_ST_RESET;
        end else begin
            status_r <= (status_r & ~statusClear) | setEv;
        end
    end
    assign status = status_r;

    // unmasked flags form the interrupt
    assign irqAny = |(status_r & ~statusMask);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqAnyPrev_r <= 1'b0;
        end else begin
            irqAnyPrev_r <= irqAny;
        end
    end

    // level follows the flags; edge gives a one-cycle pulse on rise
    assign irqAssert = irqSensitivitySelect ? irqAny : (irqAny && !irqAnyPrev_r);
    assign irqPinLevel = irqPolaritySelect ? irqAssert : !irqAssert;

    // serial pin: framer, or interrupt when uart is off
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            serialTxOut_r <= 1'b1;
        end else if (uartOn) begin
            serialTxOut_r <= (bitsLeft_r != 4'h0) ? shift_r[0] : 1'b1;
        end else begin
            serialTxOut_r <= irqPinEnable ? irqPinLevel : 1'b1;
        end
    end
    assign serialTxOut = serialTxOut_r;

    // break mode routes: sdo pin or a break message request
    assign irqSdoOe = uartBreakMode && irqPinEnable;
    assign irqSdoOut = irqSdoOe ? irqPinLevel : 1'b0;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            breakIrqMsg_r <= 1'b0;
        end else begin
            breakIrqMsg_r <= uartBreakMode && uartOn && breakMessageIrqEnable
                && irqAny && !irqAnyPrev_r;
        end
    end
    assign breakIrqMsg = breakIrqMsg_r;

    // raw filtered input is watched only through the tone strobes
    logic unusedIn;
    assign unusedIn = rxFilteredInput;
endmodule
`default_nettype wire

// ==== design/fmq_map.svh ====
/*
 * constants of the fsk modem queue and event logic: timing, status bit
 * positions, reset values. assumes a 50 MHz reference clock.
 */
`ifndef FMQ_MAP_SVH
`define FMQ_MAP_SVH

// clock and fsk timing
`define FMQ_CLK_NS 20
`define FMQ_FSK_BIT_NS 833333
`define FMQ_FAST_BIT_NS 104167
`define FMQ_CD_MARK_BITS 3
// bit period and queue delay, in cycles
`define FMQ_BIT_CYC ((`FMQ_FSK_BIT_NS + `FMQ_CLK_NS / 2) / `FMQ_CLK_NS)
`define FMQ_FAST_BIT_CYC ((`FMQ_FAST_BIT_NS + `FMQ_CLK_NS / 2) / `FMQ_CLK_NS)
`define FMQ_CD_CYC ((`FMQ_CD_MARK_BITS * `FMQ_FSK_BIT_NS + `FMQ_CLK_NS - 1) / `FMQ_CLK_NS)
`define FMQ_ENQ_CYC ((3 * `FMQ_FSK_BIT_NS / 2 + `FMQ_CLK_NS / 2) / `FMQ_CLK_NS)

// status flag positions
`define FMQ_ST_CTS_OFF 0
`define FMQ_ST_CD_ON 1
`define FMQ_ST_RX_LEVEL 2
`define FMQ_ST_RX_FULL 3
`define FMQ_ST_CD_OFF 4
`define FMQ_ST_RX_EMPTY 5
`define FMQ_ST_CTS_ON 6
`define FMQ_ST_TX_LEVEL 7
`define FMQ_ST_TX_FULL 8
`define FMQ_ST_TX_EMPTY 9
`define FMQ_ST_WIDTH 10
`define FMQ_ST_RESET 10'h000

// queue shape and serial frame
`define FMQ_QUEUE_DEPTH 16
`define FMQ_FRAME_BITS 4'ha
`define FMQ_TIMER_RESET 18'h00000

`endif

// ==== design/fmq_pkg.sv ====
/*
 * types of the fsk modem queue and event logic.
 * assumes fmq_map.svh for all numeric constants.
 */
package fmq_pkg;
    // link arbitration: listening, carrier present, sending
    typedef enum logic [2:0] {
        LINK_LISTEN = 3'b001,
        LINK_CARRIER = 3'b010,
        LINK_SEND = 3'b100
    } fmq_link_type;
endpackage

// ==== design/fmq_fifo.sv ====
/*
 * flip-flop fifo with valid/ready on both sides and a fill count.
 * assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module fmq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // occupancy
    output logic [CW-1:0] fill
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wrIdx_r;
    logic [AW-1:0] rdIdx_r;
    logic [CW-1:0] fill_r;
    logic push;
    logic pop;

    // handshakes
    assign inReady = (fill_r != CW'(DEPTH));
    assign outValid = (fill_r != '0);
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = mem_r[rdIdx_r];
    assign fill = fill_r;

    // storage write
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wrIdx_r] <= inData;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrIdx_r <= '0;
            rdIdx_r <= '0;
        end else begin
            if (push) begin
                wrIdx_r <= (wrIdx_r == AW'(DEPTH - 1)) ? '0 : wrIdx_r + 1'b1;
            end
            if (pop) begin
                rdIdx_r <= (rdIdx_r == AW'(DEPTH - 1)) ? '0 : rdIdx_r + 1'b1;
            end
        end
    end

    // fill count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fill_r <= '0;
        end else if (push && !pop) begin
            fill_r <= fill_r + 1'b1;
        end else if (pop && !push) begin
            fill_r <= fill_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/fmq_event_logic_chk.sv ====
/*
 * port assertions of fmq_event_logic, bound into every instance.
 * assumes the ports of that module and fmq_map.svh.
 */
`include "fmq_map.svh"
`timescale 1ns/100ps
`default_nettype none
module fmq_event_chk #(
    parameter int DEPTH = 16,
    parameter int CD_CYC = 24,
    parameter int CW = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // demodulator and link
    input wire logic rxMarkTone,
    input wire logic rxCarrierValid,
    input wire logic demodEnable,
    input wire logic carrierDetect,
    input wire logic modEnable,
    // receive reads
    input wire logic rxRdReq,
    input wire logic rxRdValid,
    input wire logic [CW-1:0] rxFill,
    // configuration and status
    input wire logic serialPortDisable,
    input wire logic uartBreakMode,
    input wire logic irqPinEnable,
    input wire logic irqSensitivitySelect,
    input wire logic irqPolaritySelect,
    input wire logic [`FMQ_ST_WIDTH-1:0] statusMask,
    input wire logic [`FMQ_ST_WIDTH-1:0] status,
    // pins
    input wire logic serialTxOut,
    input wire logic irqSdoOut,
    input wire logic irqSdoOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic irqAny;
    logic spiLvl;
    logic irqAnyPrev_r;
    logic spiLvlPrev_r;
    logic [17:0] toneCnt_r;
    // unmasked flags and the spi-only level, active-high pin setup
    assign irqAny = |(status & ~statusMask);
    assign spiLvl = serialPortDisable && irqPinEnable && irqSensitivitySelect && irqPolaritySelect;
    // one cycle of history for the registered uart-pin interrupt
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqAnyPrev_r <= 1'b0;
            spiLvlPrev_r <= 1'b0;
        end else begin
            irqAnyPrev_r <= irqAny;
            spiLvlPrev_r <= spiLvl;
        end
    end
    // run length of mark tone with a valid carrier
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            toneCnt_r <= 18'h00000;
        end else begin
            toneCnt_r <= (rxMarkTone && rxCarrierValid) ? toneCnt_r + 18'h00001 : 18'h00000;
        end
    end
    a_demod_listen: assert property (demodEnable == !modEnable)
        else $error("demodulator enable is not the inverse of modulator enable");
    a_cd_mark_run: assert property ($rose(carrierDetect) |->
        toneCnt_r >= CD_CYC && status[`FMQ_ST_CD_ON])
        else $error("carrier detect without a full mark run or its flag");
    a_cd_loss: assert property (carrierDetect && !rxCarrierValid |=>
        !carrierDetect && status[`FMQ_ST_CD_OFF])
        else $error("carrier detect not dropped with its flag");
    a_rd_answer: assert property (rxRdReq && serialPortDisable && rxFill != 0 |=> rxRdValid)
        else $error("queue read not answered next cycle");
    a_rd_refused: assert property (!(rxRdReq && serialPortDisable && rxFill != 0) |=> !rxRdValid)
        else $error("read data without an accepted read");
    a_rx_full_flag: assert property ($rose(rxFill == DEPTH) |-> status[`FMQ_ST_RX_FULL])
        else $error("receive queue full without its flag");
    a_rx_empty_flag: assert property (serialPortDisable && $fell(|rxFill) |-> status[`FMQ_ST_RX_EMPTY])
        else $error("receive queue emptied without its flag");
    a_cts_on_flag: assert property ($rose(modEnable) |-> status[`FMQ_ST_CTS_ON])
        else $error("modulator enabled without clear-to-send flag");
    a_cts_off_flag: assert property ($fell(modEnable) |-> ##[0:1] status[`FMQ_ST_CTS_OFF])
        else $error("send ended without clear-to-send-off flag");
    a_irq_uart_pin: assert property (spiLvlPrev_r && spiLvl |-> serialTxOut == irqAnyPrev_r)
        else $error("uart pin does not follow the unmasked flags");
    a_irq_sdo_pin: assert property (uartBreakMode && irqPinEnable && irqSensitivitySelect |->
        irqSdoOut == (irqPolaritySelect == irqAny))
        else $error("sdo interrupt level or polarity wrong");
    a_sdo_drive: assert property (irqSdoOe == (uartBreakMode && irqPinEnable))
        else $error("sdo drive enable wrong");
endmodule
bind fmq_event_logic fmq_event_chk #(.DEPTH(DEPTH), .CD_CYC(CD_CYC), .CW(CW)) u_chk (.*);
`default_nettype wire

// ==== dv/fmq_mod_partner.sv ====
/*
 * modulator-side partner: takes queued bytes while modulating, fast or slow.
 * assumes valid/ready on the modulator byte port.
 */
`timescale 1ns/100ps
`default_nettype none
module fmq_mod_partner (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // modulator byte port
    input wire logic modEnable,
    input wire logic modByteValid,
    input wire logic [7:0] modByteData,
    output logic modByteReady,
    // pacing and tallies
    input wire logic slow,
    output logic [7:0] lastByte,
    output var int taken
);
    logic [1:0] pace_r;
    // ready only while modulating, every fourth cycle when slow
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pace_r <= 2'h0;
            modByteReady <= 1'b0;
        end else begin
            pace_r <= pace_r + 2'h1;
            modByteReady <= modEnable && (!slow || pace_r == 2'h3);
        end
    end
    // tally of bytes handed over
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lastByte <= 8'h00;
            taken <= 0;
        end else if (modEnable && modByteValid && modByteReady) begin
            lastByte <= modByteData;
            taken <= taken + 1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/fmq_event_logic_tb_top.sv ====
/*
 * bench of fmq_event_logic: carrier, receive and transmit queues, uart frames.
 * assumes fmq_map.svh and short timing parameters.
 */
`include "fmq_map.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module fmq_event_logic_tb_top;
    localparam int BIT_CYC = 8;
    localparam int FAST_BIT_CYC = 4;
    localparam int CD_CYC = 24;
    localparam int ENQ_CYC = 12;
    // stimulus, valued at time zero
    logic ref_clk = 1'b0, rst_b = 1'b0, rxMarkTone = 1'b0, rxCarrierValid = 1'b0, rxByteDone = 1'b0;
    logic txWrValid = 1'b0, rxRdReq = 1'b0, rtsPin_b = 1'b1, rtsCfg = 1'b0, slow = 1'b0;
    logic serialPortDisable = 1'b1, uartBreakMode = 1'b0, irqPinEnable = 1'b0, breakMessageIrqEnable = 1'b0;
    logic irqSensitivitySelect = 1'b1, irqPolaritySelect = 1'b1;
    logic [7:0] rxByteData = 8'h00, txWrData = 8'h00;
    logic [4:0] rxThreshold = 5'h01, txThresholdField = 5'h02;
    logic [9:0] statusMask = 10'h3ff, statusClear = 10'h000;
    // observed
    logic demodEnable, carrierDetect, modEnable, modByteValid, modByteReady, txWrReady, rxRdValid;
    logic serialTxOut, irqSdoOut, irqSdoOe, breakIrqMsg;
    logic [7:0] modByteData, rxRdData, lastByte;
    logic [4:0] rxFill, txFill;
    logic [9:0] status;
    wire logic rxFilteredInput = rxMarkTone;
    int n_errors = 0, comparisons = 0, taken, brkSeen = 0;

    fmq_event_logic #(.BIT_CYC(BIT_CYC), .FAST_BIT_CYC(FAST_BIT_CYC), .CD_CYC(CD_CYC), .ENQ_CYC(ENQ_CYC)) u_dut (.*);
    fmq_mod_partner u_partner (.*);

    // clock and break-message pulse tally
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (breakIrqMsg === 1'b1) brkSeen++;

    task automatic end_sim();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_ok(input logic ok);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] wait expected 1 seen 0");
            end_sim();
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic clear_all();
        statusClear = 10'h3ff;
        step(1);
        statusClear = 10'h000;
    endtask
    task automatic rx_byte(input logic [7:0] d);
        rxByteData = d;
        rxByteDone = 1'b1;
        step(1);
        rxByteDone = 1'b0;
    endtask
    // carrier found and lost, with a send request held off meanwhile
    task automatic t_carrier();
        int n = 0;
        rxMarkTone = 1'b1;
        rxCarrierValid = 1'b1;
        while (carrierDetect !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        wait_ok(carrierDetect);
        `CHK("cd_wait", 1'b1, n >= CD_CYC);
        `CHK("cd_on", 1'b1, status[`FMQ_ST_CD_ON]);
        rtsCfg = 1'b1;
        step(3);
        `CHK("mod_held", 1'b0, modEnable);
        rxCarrierValid = 1'b0;
        step(2);
        `CHK("cd_drop", 2'b01, {carrierDetect, status[`FMQ_ST_CD_OFF]});
        rxMarkTone = 1'b0;
        step(3);
        `CHK("cts_on", 3'b110, {modEnable, status[`FMQ_ST_CTS_ON], demodEnable});
        rtsCfg = 1'b0;
        step(3);
        `CHK("cts_off", 2'b11, {status[`FMQ_ST_CTS_OFF], demodEnable});
        clear_all();
    endtask
    // spi-only receive: timing, level, overflow, interrupt pin, reads to empty
    task automatic t_spi_rx();
        int k, n = 0;
        rx_byte(8'h00);
        step(ENQ_CYC - 1);
        `CHK("enq_early", 5'h00, rxFill);
        step(3);
        `CHK("enq_late", 2'b10, {rxFill == 5'h01, status[`FMQ_ST_RX_LEVEL]});
        for (k = 1; k < 17; k++) begin
            rx_byte(k[7:0]);
            step(ENQ_CYC + 2);
        end
        `CHK("rx_full", 3'b111, {rxFill[4], status[`FMQ_ST_RX_FULL], status[`FMQ_ST_RX_LEVEL]});
        irqPinEnable = 1'b1;
        step(2);
        `CHK("irq_masked", 1'b0, serialTxOut);
        statusMask = 10'h3f7;
        step(2);
        `CHK("irq_level", 1'b1, serialTxOut);
        irqPolaritySelect = 1'b0;
        step(2);
        `CHK("irq_low", 1'b0, serialTxOut);
        irqPolaritySelect = 1'b1;
        irqSensitivitySelect = 1'b0;
        statusMask = 10'h3ff;
        step(2);
        statusMask = 10'h3f7;
        for (k = 0; k < 6; k++) begin
            step(1);
            n += (serialTxOut === 1'b1);
        end
        `CHK("irq_edge", 1'b1, n == 1);
        irqSensitivitySelect = 1'b1;
        statusMask = 10'h3ff;
        rxRdReq = 1'b1;
        for (k = 0; k < 16; k++) begin
            step(1);
            `CHK("rd_data", {1'b1, k[7:0]}, {rxRdValid, rxRdData});
        end
        step(1);
        rxRdReq = 1'b0;
        `CHK("rd_empty", 2'b01, {rxRdValid, status[`FMQ_ST_RX_EMPTY]});
        clear_all();
    endtask
    // transmit queue filled until refused, then drained by a slow modulator
    task automatic t_tx();
        int k, n = 0;
        slow = 1'b1;
        rtsPin_b = 1'b0;
        step(1);
        wait_ok(status[`FMQ_ST_CTS_ON]);
        txWrValid = 1'b1;
        for (k = 0; k < 40 && txWrReady; k++) begin
            txWrData = k[7:0];
            step(1);
        end
        txWrValid = 1'b0;
        `CHK("tx_full", 3'b101, {txFill == 5'h10, txWrReady, status[`FMQ_ST_TX_FULL]});
        while (txFill !== 5'h00 && n < 200) begin
            step(1);
            n++;
        end
        wait_ok(txFill === 5'h00);
        `CHK("tx_taken", 1'b1, taken == k && lastByte === k[7:0] - 8'h01);
        `CHK("tx_flags", 2'b11, {status[`FMQ_ST_TX_LEVEL], status[`FMQ_ST_TX_EMPTY]});
        step(11 * BIT_CYC);
        rtsPin_b = 1'b1;
        step(3);
        `CHK("tx_end", 2'b01, {modEnable, status[`FMQ_ST_CTS_OFF]});
        slow = 1'b0;
    endtask
    // automatic drain to the uart pin, normal and break rate
    task automatic t_uart();
        int m, i, n, bc;
        logic [9:0] fr;
        serialPortDisable = 1'b0;
        rxThreshold = 5'h00;
        breakMessageIrqEnable = 1'b1;
        statusMask = 10'h000;
        for (m = 0; m < 2; m++) begin
            uartBreakMode = m[0];
            irqPinEnable = m[0];
            bc = m ? FAST_BIT_CYC : BIT_CYC;
            fr = {1'b1, 8'ha5 ^ m[7:0], 1'b0};
            clear_all();
            brkSeen = 0;
            rx_byte(fr[8:1]);
            n = 0;
            while (serialTxOut !== 1'b0 && n < 40) begin
                step(1);
                n++;
            end
            wait_ok(serialTxOut === 1'b0);
            step(bc / 2);
            for (i = 0; i < 10; i++) begin
                `CHK("frame", fr[i], serialTxOut);
                step(bc);
            end
            `CHK("brk_msg", m[0], brkSeen != 0);
            `CHK("drained", 5'h00, rxFill);
        end
    endtask

    // reset, then every scenario in turn
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        `CHK("rst_status", 10'h000, status);
        `CHK("rst_pins", 4'he, {demodEnable, serialTxOut, txWrReady, modByteValid});
        t_carrier();
        t_spi_rx();
        t_tx();
        t_uart();
        end_sim();
    end
endmodule
`default_nettype wire
